/* File: src/aci_irq.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module aci_irq #(
  parameter int SEC_CYCLES = aci_pkg::SEC_CYC,
  parameter int DEPTH      = aci_pkg::Q_DEPTH
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              smp_stb,
  input  wire aci_pkg::aci_axes_t smp_data,
  input  wire aci_pkg::aci_mag_t  smp_mag,
  output logic                   irq_out_a,
  output logic                   irq_out_b
);
  import aci_pkg::*;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_LAT  = 3'b010,
    DS_WIN  = 3'b100
  } aci_ds_t;

  logic [7:0]  cfg_ff [64];
  logic [5:0]  awix_ff;
  logic [7:0]  wbyte_ff;
  logic        wlane_ff;
  logic [5:0]  ar_ix;
  logic        wr_go;
  logic        ar_hs;
  logic        rd_flags;
  logic        rd_data;
  aci_axes_t   smp_ff;
  aci_flags_t  fl;
  aci_qmode_t  qmode;
  logic [5:0]  cnt_ff;
  logic [4:0]  wm_lvl;
  logic        unread_ff;
  logic        ovr_ff;
  logic        wm_ff;
  logic        sshock_ff;
  logic        dshock_ff;
  logic        act_ff;
  logic        inact_ff;
  logic [7:0]  run_ff;
  logic        above;
  logic        above_ff;
  logic        shock_ev;
  logic        dbl_ev;
  logic        second_ff;
  aci_ds_t     ds_ff;
  logic [7:0]  dtmr_ff;
  logic        act_hit;
  logic        still_ff;
  logic [31:0] div_ff;
  logic        sec_tick;
  logic [7:0]  stime_ff;
  logic        inact_ev;
  logic        inv;
  logic [7:0]  act_pins;

  function automatic logic is_rw(input logic [5:0] ix);
    return (ix == IX_SHOCK_THR) || (ix >= IX_SHOCK_DUR &&
      ix <= IX_AXIS_SEL) || ix == IX_IRQ_EN ||
      ix == IX_IRQ_ROUTE || ix == IX_FORMAT ||
      ix == IX_QUEUE_CTL;
  endfunction

  function automatic logic [2:0] gt3(input aci_mag_t m,
                                     input logic [7:0] t);
    return {m.x > t, m.y > t, m.z > t};
  endfunction

  // Register file and write side
  assign wr_go = !awready && !wready && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready  <= 1'b1;
      awix_ff  <= 6'h00;
    end
    else if (awvalid && awready)
    begin
      awready  <= 1'b0;
      awix_ff  <= awaddr[7:2];
    end
    else if (wr_go)
      awready  <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready   <= 1'b1;
      wbyte_ff <= CFG_RST;
      wlane_ff <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wready   <= 1'b0;
      wbyte_ff <= wdata[7:0];
      wlane_ff <= wstrb[0];
    end
    else if (wr_go)
      wready   <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp  <= is_rw(awix_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 64; i++)
        cfg_ff[i] <= CFG_RST;
    end
    else if (wr_go && wlane_ff && is_rw(awix_ff))
      cfg_ff[awix_ff] <= wbyte_ff;
  end

  // Read side with read side effects
  assign ar_ix    = araddr[7:2];
  assign ar_hs    = arvalid && arready;
  assign rd_flags = ar_hs && ar_ix == IX_IRQ_FLAGS;
  assign rd_data  = ar_hs && ar_ix >= IX_SAMPLE0 &&
                    ar_ix <= IX_SAMPLE5;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
      if (is_rw(ar_ix))
        rdata[7:0] <= cfg_ff[ar_ix];
      else if (ar_ix == IX_IRQ_FLAGS)
        rdata[7:0] <= fl;
      else if (rd_data)
        rdata[7:0] <= 8'({smp_ff.z, smp_ff.y, smp_ff.x} >>
                         (8 * (ar_ix - IX_SAMPLE0)));
      else if (ar_ix == IX_QUEUE_LVL)
        rdata[5:0] <= cnt_ff;
      else
        rresp <= RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Sample holding and queue level
  assign qmode  = aci_qmode_t'(cfg_ff[IX_QUEUE_CTL][QMODE_LSB +: 2]);
  assign wm_lvl = cfg_ff[IX_QUEUE_CTL][QWM_MSB:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      smp_ff <= '0;
    else if (smp_stb)
      smp_ff <= smp_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || qmode == QM_BYPASS)
      cnt_ff <= 6'h00;
    else if (smp_stb && !(rd_data && ar_ix == IX_SAMPLE0))
    begin
      if (cnt_ff < 6'(DEPTH))
        cnt_ff <= cnt_ff + 6'h01;
    end
    else if (!smp_stb && rd_data && ar_ix == IX_SAMPLE0 &&
             cnt_ff != 6'h00)
      cnt_ff <= cnt_ff - 6'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unread_ff <= 1'b0;
    else if (smp_stb)
      unread_ff <= 1'b1;
    else if (rd_data)
      unread_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovr_ff <= 1'b0;
    else if (qmode == QM_BYPASS && smp_stb && unread_ff)
      ovr_ff <= 1'b1;
    else if (rd_data || qmode != QM_BYPASS)
      ovr_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wm_ff <= 1'b0;
    else
      wm_ff <= fl.watermark;
  end

  // Shock detection counted in samples
  assign above    = |gt3(smp_mag, cfg_ff[IX_SHOCK_THR]);
  assign shock_ev = smp_stb && !above && run_ff != 8'h00 &&
                    run_ff < cfg_ff[IX_SHOCK_DUR];
  assign dbl_ev   = ds_ff == DS_WIN && shock_ev && second_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_ff   <= 8'h00;
      above_ff <= 1'b0;
    end
    else if (smp_stb)
    begin
      above_ff <= above;
      if (!above)
        run_ff <= 8'h00;
      else if (run_ff != 8'hff)
        run_ff <= run_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ds_ff     <= DS_IDLE;
      dtmr_ff   <= 8'h00;
      second_ff <= 1'b0;
    end
    else if (smp_stb)
    begin
      dtmr_ff <= dtmr_ff + 8'h01;
      unique case (ds_ff)
        DS_IDLE:
          if (shock_ev)
          begin
            ds_ff   <= DS_LAT;
            dtmr_ff <= 8'h00;
          end
        DS_LAT:
          if (dtmr_ff >= cfg_ff[IX_SHOCK_LAT])
          begin
            ds_ff     <= DS_WIN;
            dtmr_ff   <= 8'h00;
            second_ff <= 1'b0;
          end
        DS_WIN:
        begin
          if (above && !above_ff &&
              dtmr_ff < cfg_ff[IX_SHOCK_WIN])
            second_ff <= 1'b1;
          if (dbl_ev || (!above && run_ff != 8'h00) ||
              (!second_ff && dtmr_ff >= cfg_ff[IX_SHOCK_WIN]))
            ds_ff <= DS_IDLE;
        end
        default:
          ds_ff <= DS_IDLE;
      endcase
    end
  end

  // Motion and stillness
  assign act_hit = smp_stb && |(gt3(smp_mag, cfg_ff[IX_MOT_THR]) &
                   cfg_ff[IX_AXIS_SEL][MOT_AX_LSB +: 3]);
  assign sec_tick = div_ff == 32'(SEC_CYCLES - 1);
  assign inact_ev = sec_tick && still_ff &&
                    stime_ff > cfg_ff[IX_STILL_TIME];

  always_ff @(posedge aclk)
  begin
    if (!aresetn || sec_tick)
      div_ff <= 32'h0000_0000;
    else
      div_ff <= div_ff + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      still_ff <= 1'b0;
    else if (smp_stb)
      still_ff <= !(|(gt3(smp_mag, cfg_ff[IX_STILL_THR] - 8'h01) &
        cfg_ff[IX_AXIS_SEL][STILL_AX_LSB +: 3])) &&
        cfg_ff[IX_STILL_THR] != 8'h00;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !still_ff)
      stime_ff <= 8'h00;
    else if (sec_tick && stime_ff != 8'hff)
      stime_ff <= stime_ff + 8'h01;
  end

  // Sticky flags, set wins over a clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sshock_ff <= 1'b0;
      dshock_ff <= 1'b0;
      act_ff    <= 1'b0;
      inact_ff  <= 1'b0;
    end
    else
    begin
      sshock_ff <= shock_ev || (sshock_ff && !rd_flags);
      dshock_ff <= dbl_ev || (dshock_ff && !rd_flags);
      act_ff    <= act_hit || (act_ff && !rd_flags);
      inact_ff  <= inact_ev || (inact_ff && !rd_flags);
    end
  end

  always_comb
  begin
    fl              = '0;
    fl.data_ready   = unread_ff || cnt_ff != 6'h00;
    fl.single_shock = sshock_ff;
    fl.double_shock = dshock_ff;
    fl.activity     = act_ff;
    fl.inactivity   = inact_ff;
    fl.watermark    = qmode != QM_BYPASS &&
      (cnt_ff == {1'b0, wm_lvl} ||
       (wm_ff && cnt_ff >= {1'b0, wm_lvl}));
    fl.overrun      = qmode == QM_BYPASS ? ovr_ff :
                      cnt_ff == 6'(DEPTH);
  end

  // Pin drive
  assign inv      = cfg_ff[IX_FORMAT][FMT_INVERT];
  assign act_pins = fl & cfg_ff[IX_IRQ_EN];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end
    else
    begin
      irq_out_a <= |(act_pins & ~cfg_ff[IX_IRQ_ROUTE]) ^ inv;
      irq_out_b <= |(act_pins & cfg_ff[IX_IRQ_ROUTE]) ^ inv;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_pin_a;
    1 |=> irq_out_a == ($past(|(act_pins & ~cfg_ff[IX_IRQ_ROUTE]))
                        ^ $past(inv));
  endproperty
  a_pin_a: assert property (p_pin_a)
    else $error("pin a mismatch");

  property p_pin_b;
    $past(cfg_ff[IX_IRQ_EN]) == 8'h00 |-> irq_out_b == $past(inv);
  endproperty
  a_pin_b: assert property (p_pin_b)
    else $error("pin b active while nothing enabled");

  property p_inv;
    inv && act_pins == 8'h00 ##1 inv |-> irq_out_a && irq_out_b;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted idle level wrong");

  property p_flag_clr;
    rd_flags && !act_hit |=> !act_ff;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("activity not cleared by read");

  property p_data_clr;
    rd_data && !smp_stb |=> !unread_ff;
  endproperty
  a_data_clr: assert property (p_data_clr)
    else $error("unread not cleared by data read");

  property p_ready;
    smp_stb |=> fl.data_ready [*1];
  endproperty
  a_ready: assert property (p_ready)
    else $error("data ready missing");

  property p_shock;
    shock_ev |=> sshock_ff ##1 (sshock_ff || $past(rd_flags));
  endproperty
  a_shock: assert property (p_shock)
    else $error("single shock lost");

  property p_dbl;
    dbl_ev |=> dshock_ff && ds_ff == DS_IDLE;
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("double shock lost");

  property p_wm_low;
    cnt_ff < {1'b0, wm_lvl} |-> !fl.watermark;
  endproperty
  a_wm_low: assert property (p_wm_low)
    else $error("watermark above count");

  property p_ovr_full;
    qmode != QM_BYPASS && cnt_ff == 6'(DEPTH) |-> fl.overrun;
  endproperty
  a_ovr_full: assert property (p_ovr_full)
    else $error("full queue without overrun");

  property p_ovr_byp;
    qmode == QM_BYPASS && smp_stb && unread_ff
      ##1 qmode == QM_BYPASS |-> fl.overrun;
  endproperty
  a_ovr_byp: assert property (p_ovr_byp)
    else $error("bypass overrun missing");

  property p_cap;
    cnt_ff <= 6'(DEPTH);
  endproperty
  a_cap: assert property (p_cap)
    else $error("queue level above depth");

  c_dbl: cover property (dbl_ev);
  c_wm: cover property (fl.watermark && qmode == QM_STREAM);
  c_inact: cover property (inact_ev);
  c_pin: cover property (inv ##1 !irq_out_a);
endmodule

/* File: src/aci_pkg.sv */
package aci_pkg;
  // Clock and time base
  localparam int CLK_HZ     = 25_000_000;
  localparam int STILL_UNIT_S = 1;
  localparam int SEC_CYC    = CLK_HZ * STILL_UNIT_S;
  localparam int Q_DEPTH    = 32;
  localparam int ADDR_W     = 8;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IX_SHOCK_THR  = 6'h1d;
  localparam logic [5:0] IX_SHOCK_DUR  = 6'h21;
  localparam logic [5:0] IX_SHOCK_LAT  = 6'h22;
  localparam logic [5:0] IX_SHOCK_WIN  = 6'h23;
  localparam logic [5:0] IX_MOT_THR    = 6'h24;
  localparam logic [5:0] IX_STILL_THR  = 6'h25;
  localparam logic [5:0] IX_STILL_TIME = 6'h26;
  localparam logic [5:0] IX_AXIS_SEL   = 6'h27;
  localparam logic [5:0] IX_IRQ_EN     = 6'h2e;
  localparam logic [5:0] IX_IRQ_ROUTE  = 6'h2f;
  localparam logic [5:0] IX_IRQ_FLAGS  = 6'h30;
  localparam logic [5:0] IX_FORMAT     = 6'h31;
  localparam logic [5:0] IX_SAMPLE0    = 6'h32;
  localparam logic [5:0] IX_SAMPLE5    = 6'h37;
  localparam logic [5:0] IX_QUEUE_CTL  = 6'h38;
  localparam logic [5:0] IX_QUEUE_LVL  = 6'h3a;

  // Field positions and reset values
  localparam int FMT_INVERT  = 5;
  localparam int QMODE_LSB   = 6;
  localparam int QWM_MSB     = 4;
  localparam int MOT_AX_LSB  = 4;
  localparam int STILL_AX_LSB = 0;
  localparam logic [7:0] CFG_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    QM_BYPASS  = 2'b00,
    QM_FIFO    = 2'b01,
    QM_STREAM  = 2'b10,
    QM_TRIGGER = 2'b11
  } aci_qmode_t;

  typedef struct packed {
    logic data_ready;
    logic single_shock;
    logic double_shock;
    logic activity;
    logic inactivity;
    logic spare;
    logic watermark;
    logic overrun;
  } aci_flags_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } aci_axes_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } aci_mag_t;
endpackage

/* File: bench/aci_host_model.sv */
`timescale 1ns/10ps
module aci_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic irq_out_a,
  input  wire logic irq_out_b,
  input  wire logic invert,
  output logic      req_a_ff,
  output logic      req_b_ff
);
  // Host takes the pin level through the programmed polarity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_a_ff <= 1'b0;
      req_b_ff <= 1'b0;
    end
    else
    begin
      req_a_ff <= irq_out_a ^ invert;
      req_b_ff <= irq_out_b ^ invert;
    end
  end
endmodule

/* File: bench/accel_interrupt_logic_test.sv */
`timescale 1ns/10ps
module accel_interrupt_logic_test;
  import aci_pkg::*;
  localparam int SECS = 10;
  localparam int DEP  = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, en_v, rt_v, v;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, smp_stb;
  logic        irq_out_a, irq_out_b, inv_v, ha, hb;
  aci_axes_t   smp_data, lastd;
  aci_mag_t    smp_mag;
  logic [5:0]  rw_ix [12];
  int          seed = 56;
  int          mismatches = 0;
  int          n_compared = 0;

  aci_irq #(.SEC_CYCLES(SECS), .DEPTH(DEP)) u_aci_irq (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .smp_stb, .smp_data, .smp_mag, .irq_out_a,
    .irq_out_b
  );
  aci_host_model u_aci_host_model (
    .aclk, .aresetn, .irq_out_a, .irq_out_b, .invert(inv_v),
    .req_a_ff(ha), .req_b_ff(hb)
  );

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] val);
    @(posedge aclk);
    awaddr  <= {ix, 2'b00};
    wdata   <= {24'h0, val};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    if (ix == IX_IRQ_EN) en_v <= val;
    if (ix == IX_IRQ_ROUTE) rt_v <= val;
    if (ix == IX_FORMAT) inv_v <= val[FMT_INVERT];
  endtask

  task automatic rd(input logic [5:0] ix);
    @(posedge aclk);
    araddr  <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic smp(input aci_mag_t m);
    @(posedge aclk);
    lastd = 48'({$random(seed), $random(seed)});
    smp_stb  <= 1'b1;
    smp_mag  <= m;
    smp_data <= lastd;
    @(posedge aclk);
    smp_stb <= 1'b0;
  endtask

  task automatic cf(input logic [7:0] mask, input logic [7:0] e);
    rd(IX_IRQ_FLAGS);
    chk(d & {24'h0, mask}, {24'h0, e}, "flags");
  endtask

  // Expected pin level from latched flags, enables, route and polarity
  function automatic logic ep(input logic [7:0] f, input logic b);
    return (|(f & en_v & (b ? rt_v : ~rt_v))) ^ inv_v;
  endfunction

  task automatic pc(input logic [7:0] f);
    repeat (3) @(posedge aclk);
    chk(32'(irq_out_a), 32'(ep(f, 1'b0)), "pin a");
    chk(32'(irq_out_b), 32'(ep(f, 1'b1)), "pin b");
    chk(32'(ha), 32'(ep(f, 1'b0) ^ inv_v), "host a");
    chk(32'(hb), 32'(ep(f, 1'b1) ^ inv_v), "host b");
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, smp_stb} = '0;
    {awaddr, araddr, wdata, wstrb, smp_data, smp_mag} = '0;
    {en_v, rt_v, inv_v, lastd} = '0;
    rw_ix = '{IX_SHOCK_THR, IX_SHOCK_DUR, IX_SHOCK_LAT, IX_SHOCK_WIN,
              IX_MOT_THR, IX_STILL_THR, IX_STILL_TIME, IX_AXIS_SEL,
              IX_IRQ_EN, IX_IRQ_ROUTE, IX_FORMAT, IX_QUEUE_CTL};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    pc(8'h00);
    foreach (rw_ix[i])
    begin
      v = 8'($random(seed));
      rd(rw_ix[i]);
      chk(d, {24'h0, CFG_RST}, "reset value");
      wr(rw_ix[i], v);
      chk(32'(r), 32'(RESP_OKAY), "write resp");
      rd(rw_ix[i]);
      chk(d, {24'h0, v}, "readback");
      wr(rw_ix[i], 8'h00);
    end
    rd(6'h00);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    chk(d, 32'h0, "unmapped data");
    wr(IX_IRQ_FLAGS, 8'hff);
    chk(32'(r), 32'(RESP_SLVERR), "read-only write");
    rd(IX_IRQ_FLAGS);
    wr(IX_IRQ_ROUTE, 8'h02);
    wr(IX_IRQ_EN, 8'h80);
    smp(24'h0);
    pc(8'h80);
    smp(24'h0);
    cf(8'h81, 8'h81);
    cf(8'h01, 8'h01);
    rd(IX_SAMPLE0);
    chk(d, {24'h0, lastd.x[7:0]}, "x low");
    rd(IX_SAMPLE0 + 6'd1);
    chk(d, {24'h0, lastd.x[15:8]}, "x high");
    rd(IX_SAMPLE5);
    chk(d, {24'h0, lastd.z[15:8]}, "z high");
    cf(8'h81, 8'h00);
    pc(8'h00);
    wr(IX_IRQ_EN, 8'h00);
    wr(IX_IRQ_ROUTE, 8'h80);
    wr(IX_IRQ_EN, 8'h80);
    smp(24'h0);
    pc(8'h80);
    wr(IX_FORMAT, 8'h20);
    pc(8'h80);
    rd(IX_SAMPLE0);
    pc(8'h00);
    wr(IX_FORMAT, 8'h00);
    wr(IX_IRQ_EN, 8'h00);
    wr(IX_AXIS_SEL, 8'h40);
    wr(IX_MOT_THR, 8'd10);
    wr(IX_IRQ_ROUTE, 8'h00);
    wr(IX_IRQ_EN, 8'hff);
    smp({8'd0, 8'd30, 8'd0});
    cf(8'h10, 8'h00);
    smp({8'd20, 8'd0, 8'd0});
    pc(8'h91);
    cf(8'h10, 8'h10);
    cf(8'h10, 8'h00);
    rd(IX_SAMPLE0);
    wr(IX_SHOCK_THR, 8'd50);
    wr(IX_SHOCK_DUR, 8'd3);
    smp(24'h0);
    smp({8'd60, 8'd0, 8'd0});
    smp(24'h0);
    cf(8'h40, 8'h40);
    repeat (3) smp({8'd0, 8'd0, 8'd60});
    smp(24'h0);
    cf(8'h40, 8'h00);
    wr(IX_SHOCK_LAT, 8'd1);
    wr(IX_SHOCK_WIN, 8'd5);
    smp({8'd60, 8'd0, 8'd0});
    repeat (3) smp(24'h0);
    smp({8'd60, 8'd0, 8'd0});
    smp(24'h0);
    cf(8'h60, 8'h60);
    wr(IX_SHOCK_DUR, 8'd0);
    wr(IX_AXIS_SEL, 8'h07);
    wr(IX_STILL_THR, 8'd10);
    wr(IX_STILL_TIME, 8'd1);
    smp({8'd1, 8'd1, 8'd1});
    repeat (5 * SECS) @(posedge aclk);
    cf(8'h08, 8'h08);
    wr(IX_STILL_THR, 8'd0);
    rd(IX_IRQ_FLAGS);
    rd(IX_SAMPLE0);
    wr(IX_IRQ_EN, 8'h00);
    wr(IX_IRQ_ROUTE, 8'h02);
    wr(IX_IRQ_EN, 8'h03);
    for (int m = 1; m < 4; m++)
    begin
      wr(IX_QUEUE_CTL, 8'h00);
      wr(IX_QUEUE_CTL, {2'(m), 6'd3});
      repeat (2) smp(24'h0);
      cf(8'h03, 8'h00);
      smp(24'h0);
      cf(8'h03, 8'h02);
      pc(8'h02);
      repeat (DEP - 2) smp(24'h0);
      rd(IX_QUEUE_LVL);
      chk(d, 32'(DEP), "level");
      cf(8'h03, 8'h03);
      pc(8'h03);
      rd(IX_SAMPLE0);
      cf(8'h03, 8'h02);
      repeat (DEP - 4) rd(IX_SAMPLE0);
      cf(8'h03, 8'h02);
      rd(IX_SAMPLE0);
      cf(8'h03, 8'h00);
    end
    wr(IX_QUEUE_CTL, 8'h00);
    aresetn <= 1'b0;
    {en_v, rt_v, inv_v} <= '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(irq_out_a), 32'h0, "pin a after reset");
    pc(8'h00);
    rd(IX_IRQ_EN);
    chk(d, {24'h0, CFG_RST}, "enable after reset");
    final_report;
  end
endmodule
